// *** src/acs_pkg.sv ***
// package: constants and types for the calibration sequencer
// assumes one 10 MHz clock that also serves as the converter master clock

package acs_pkg;
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam logic [4:0] MOD_DIV = 5'h10;

   localparam logic [2:0] ADDR_MODE = 3'h0;
   localparam logic [2:0] ADDR_FILTER = 3'h1;
   localparam logic [2:0] ADDR_DATA = 3'h2;
   localparam logic [2:0] ADDR_OFFSET = 3'h3;
   localparam logic [2:0] ADDR_GAIN = 3'h4;
   localparam logic [2:0] ADDR_STATUS = 3'h5;

   localparam int MD_LSB = 0;
   localparam int RN_LSB = 3;
   localparam int BIP_BIT = 6;
   localparam int CH_LSB = 7;
   localparam logic [31:0] MODE_MASK = 32'h000001ff;
   localparam int CHP_BIT = 0;
   localparam int SKIP_BIT = 1;
   localparam int SF_LSB = 8;
   localparam logic [31:0] FILTER_MASK = 32'h0000ff03;

   localparam logic [2:0] CODE_IDLE = 3'h0;
   localparam logic [2:0] CODE_INT_ZERO = 3'h4;
   localparam logic [2:0] CODE_INT_FULL = 3'h5;
   localparam logic [2:0] CODE_SYS_ZERO = 3'h6;
   localparam logic [2:0] CODE_SYS_FULL = 3'h7;

   localparam logic [5:0] STEP_PER_CHOP = 6'h16;
   localparam logic [5:0] STEP_PER_PLAIN = 6'h18;
   localparam logic [6:0] FULL_PER_CHOP = 7'h2c;
   localparam logic [6:0] FULL_PER_PLAIN = 7'h30;

   localparam logic [31:0] MODE_RST = 32'h00000000;
   localparam logic [31:0] FILTER_RST = 32'h00000801;
   localparam logic [23:0] OFFSET_RST = 24'h800000;
   localparam logic [23:0] GAIN_RST = 24'h800000;
   localparam logic [23:0] BIPOLAR_MID = 24'h800000;
   localparam int GAIN_SHIFT = 23;

   typedef enum logic [1:0] {
      ACS_IDLE = 2'b00,
      ACS_ZERO = 2'b01,
      ACS_FULL = 2'b11
   } acs_state_t;
endpackage

// *** src/acs_divider.sv ***
// file: tick divider, one pulse every limit steps
// assumes limit is at least one
`timescale 1ns/10ps
`default_nettype none
module acs_divider #(
   parameter int W = 8
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic clear,
   input wire logic step,
   input wire logic [W-1:0] limit,
   output logic tick
);
   logic [W-1:0] cnt;
   logic [W-1:0] next_cnt;
   logic wrap;

   assign wrap = step && (cnt >= limit - W'(1));
   assign tick = wrap && !clear;
   assign next_cnt = (clear || wrap) ? '0 : (step ? cnt + W'(1) : cnt);

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cnt <= '0;
      end else begin
         cnt <= next_cnt;
      end
   end
endmodule
`default_nettype wire

// *** src/acs_sequencer.sv ***
// file: calibration sequencer with register port and offset/gain correction
// assumes filter results arrive from same-clock logic; sys_clk is master clock
//
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module acs_sequencer (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [2:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic [23:0] filt_data,
   input wire logic filt_valid,
   output logic rdy_n,
   output logic [2:0] conv_mode,
   output logic [23:0] conv_data,
   output logic conv_valid,
   output logic fe_short_inputs,
   output logic fe_ref_fullscale,
   output logic [2:0] pga_range,
   output logic bipolar,
   output logic filt_chop,
   output logic filt_skip_eff
);
   import acs_pkg::*;

   acs_state_t state;
   acs_state_t next_state;
   logic [31:0] mode_reg;
   logic [31:0] next_mode;
   logic [31:0] filter_reg;
   logic [2:0] cal_code;
   logic [5:0] per_cnt;
   logic [5:0] next_per;
   logic [23:0] offset_coef [4];
   logic [23:0] gain_coef [4];
   logic [23:0] last_filt;
   logic data_ready;
   logic next_ready;
   logic [31:0] rd_mux;
   logic mod_tick;
   logic out_tick;

   // register port decode
   logic wr_mode;
   logic wr_filter;
   logic wr_offset;
   logic wr_gain;
   logic rd_data;
   logic [2:0] wcode;
   logic [2:0] mode_sel;
   logic [1:0] chan;
   logic chop;
   logic [7:0] sf;
   logic [7:0] sf_lim;

   assign wr_mode = reg_wr && (reg_addr == ADDR_MODE);
   assign wr_filter = reg_wr && (reg_addr == ADDR_FILTER);
   assign wr_offset = reg_wr && (reg_addr == ADDR_OFFSET);
   assign wr_gain = reg_wr && (reg_addr == ADDR_GAIN);
   assign rd_data = reg_rd && (reg_addr == ADDR_DATA);
   assign wcode = reg_wdata[MD_LSB+:3];
   assign mode_sel = mode_reg[MD_LSB+:3];
   assign chan = mode_reg[CH_LSB+:2];
   assign chop = filter_reg[CHP_BIT];
   assign sf = filter_reg[SF_LSB+:8];
   assign sf_lim = (sf == 8'h00) ? 8'h01 : sf;

   // sequencing terms
   logic busy;
   logic cal_start;
   logic abort;
   logic [5:0] step_len;
   logic step_done;
   logic two_step;
   logic cal_finish;
   logic conv_fire;

   assign busy = (state != ACS_IDLE);
   // any calibration code starts at once, no history needed
   assign cal_start = wr_mode && wcode[2];
   assign abort = wr_mode && !wcode[2] && busy;
   assign step_len = chop ? STEP_PER_CHOP : STEP_PER_PLAIN;
   assign step_done = busy && out_tick && !wr_mode && (per_cnt == step_len - 6'h01);
   assign two_step = (cal_code == CODE_INT_FULL) && (state == ACS_ZERO);
   assign cal_finish = step_done && !two_step;
   assign conv_fire = filt_valid && !busy && (mode_sel != CODE_IDLE) && !mode_sel[2];

   // modulator cycle, then output period of sf modulator cycles (one cycle when sf is zero)
   acs_divider #(.W(5)) u_mod_div (
      .sys_clk(sys_clk),
      .rst(rst),
      .clear(1'b0),
      .step(1'b1),
      .limit(MOD_DIV),
      .tick(mod_tick)
   );

   acs_divider #(.W(8)) u_out_div (
      .sys_clk(sys_clk),
      .rst(rst),
      .clear(cal_start),
      .step(mod_tick),
      .limit(sf_lim),
      .tick(out_tick)
   );

   always_comb begin
      next_state = state;
      if (cal_start) begin
         if (wcode == CODE_SYS_FULL) begin
            next_state = ACS_FULL;
         end else begin
            next_state = ACS_ZERO;
         end
      end else if (abort) begin
         next_state = ACS_IDLE;
      end else begin
         case (state)
            ACS_ZERO: begin
               if (step_done) begin
                  next_state = two_step ? ACS_FULL : ACS_IDLE;
               end
            end
            ACS_FULL: begin
               if (step_done) begin
                  next_state = ACS_IDLE;
               end
            end
            default: begin
               next_state = ACS_IDLE;
            end
         endcase
      end
   end

   assign next_per = (cal_start || step_done) ? 6'h00 :
                     ((busy && out_tick) ? per_cnt + 6'h01 : per_cnt);

   // a host write beats the end-of-calibration clear
   assign next_mode = wr_mode ? (reg_wdata & MODE_MASK) :
                      (cal_finish ? {mode_reg[31:3], CODE_IDLE} : mode_reg);

   assign next_ready = cal_start ? 1'b0 :
                       ((conv_fire || cal_finish) ? 1'b1 :
                       (rd_data ? 1'b0 : data_ready));

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state <= ACS_IDLE;
         per_cnt <= 6'h00;
         mode_reg <= MODE_RST;
         data_ready <= 1'b0;
         rdy_n <= 1'b1;
      end else begin
         state <= next_state;
         per_cnt <= next_per;
         mode_reg <= next_mode;
         data_ready <= next_ready;
         rdy_n <= (next_state != ACS_IDLE) || !next_ready;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         filter_reg <= FILTER_RST;
         cal_code <= CODE_IDLE;
         last_filt <= 24'h000000;
      end else begin
         if (wr_filter) begin
            filter_reg <= reg_wdata & FILTER_MASK;
         end
         if (cal_start) begin
            cal_code <= wcode;
         end
         if (filt_valid) begin
            last_filt <= filt_data;
         end
      end
   end

   // coefficients per channel; host writes win over calibration
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < 4; i++) begin
            offset_coef[i] <= OFFSET_RST;
            gain_coef[i] <= GAIN_RST;
         end
      end else begin
         if (wr_offset) begin
            offset_coef[chan] <= reg_wdata[23:0];
         end else if (step_done && (state == ACS_ZERO)) begin
            offset_coef[chan] <= last_filt;
         end
         if (wr_gain) begin
            gain_coef[chan] <= reg_wdata[23:0];
         end else if (step_done && (state == ACS_FULL)) begin
            gain_coef[chan] <= last_filt;
         end
      end
   end

   // correction path
   logic [23:0] off_cur;
   logic [23:0] gain_cur;
   logic signed [24:0] diff;
   logic signed [49:0] prod;
   logic signed [49:0] shifted;
   logic [23:0] corr;

   assign off_cur = offset_coef[chan];
   assign gain_cur = gain_coef[chan];
   assign diff = $signed({1'b0, filt_data}) - $signed({1'b0, off_cur});
   assign prod = diff * $signed({1'b0, gain_cur});
   assign shifted = prod >>> GAIN_SHIFT;
   // zero differential input lands mid-scale in bipolar ranges
   assign corr = shifted[23:0] + (bipolar ? BIPOLAR_MID : 24'h000000);

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         conv_data <= 24'h000000;
         conv_valid <= 1'b0;
      end else begin
         conv_valid <= conv_fire;
         if (conv_fire) begin
            conv_data <= corr;
         end
      end
   end

   // front end and filter steering
   assign fe_short_inputs = (state == ACS_ZERO) && (cal_code != CODE_SYS_ZERO);
   assign fe_ref_fullscale = (state == ACS_FULL) && (cal_code == CODE_INT_FULL);
   assign pga_range = mode_reg[RN_LSB+:3];
   assign bipolar = mode_reg[BIP_BIT];
   assign filt_chop = chop;
   assign filt_skip_eff = filter_reg[SKIP_BIT] && !busy;
   assign conv_mode = mode_sel[2] ? CODE_IDLE : mode_sel;

   always_comb begin
      rd_mux = 32'h00000000;
      if (reg_addr == ADDR_MODE) begin
         rd_mux = mode_reg;
      end else if (reg_addr == ADDR_FILTER) begin
         rd_mux = filter_reg;
      end else if (reg_addr == ADDR_DATA) begin
         rd_mux = {8'h00, conv_data};
      end else if (reg_addr == ADDR_OFFSET) begin
         rd_mux = {8'h00, off_cur};
      end else if (reg_addr == ADDR_GAIN) begin
         rd_mux = {8'h00, gain_cur};
      end else if (reg_addr == ADDR_STATUS) begin
         rd_mux = {28'h0000000, state, data_ready, busy};
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= 32'h00000000;
      end else begin
         reg_rdata <= reg_rd ? rd_mux : 32'h00000000;
      end
   end

   // checking helpers
   logic [6:0] tick_total;
   logic [6:0] full_len;

   assign full_len = chop ? FULL_PER_CHOP : FULL_PER_PLAIN;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         tick_total <= 7'h00;
      end else if (cal_start) begin
         tick_total <= 7'h00;
      end else if (busy && out_tick) begin
         tick_total <= tick_total + 7'h01;
      end
   end

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   sequence s_cal_write(logic [2:0] code);
      wr_mode && (wcode == code);
   endsequence

   sequence s_zero_entry;
      (state == ACS_ZERO) && fe_short_inputs && rdy_n;
   endsequence

   a_zero_start: assert property (s_cal_write(CODE_INT_ZERO) |=> s_zero_entry)
      else $error("internal zero-scale did not start");

   a_zero_len: assert property (
      (cal_finish && (cal_code != CODE_INT_FULL)) |-> (tick_total == {1'b0, step_len} - 7'h01))
      else $error("zero-scale length wrong");

   a_full_len: assert property (
      (cal_finish && (cal_code == CODE_INT_FULL)) |-> (tick_total == full_len - 7'h01))
      else $error("internal full-scale length wrong");

   a_mode_idle: assert property ((cal_finish && !wr_mode) |=> (mode_sel == CODE_IDLE) && !busy)
      else $error("mode field not returned to idle");

   a_rdy_busy: assert property (busy |-> rdy_n)
      else $error("ready low during calibration");

   a_rdy_done: assert property (cal_finish |=> !rdy_n)
      else $error("ready not low after calibration");

   a_no_result: assert property (busy |=> !conv_valid)
      else $error("conversion result during calibration");

   a_rdy_rise: assert property (cal_start |-> ##[1:16] rdy_n)
      else $error("ready not raised within a modulator cycle");

   a_bip_mid: assert property (
      (conv_fire && bipolar && (filt_data == off_cur)) |=> (conv_data == BIPOLAR_MID))
      else $error("bipolar zero input not mid-scale");

   a_full_steps: assert property (
      (two_step && step_done) |=> (state == ACS_FULL) && fe_ref_fullscale && !fe_short_inputs)
      else $error("internal full-scale second step missing");

   a_skip_forced: assert property (busy |-> !filt_skip_eff)
      else $error("skip active during calibration");

   a_pass_mode: assert property (!mode_sel[2] |-> (conv_mode == mode_sel))
      else $error("conversion code not passed on");

   a_offset_store: assert property (
      (step_done && (state == ACS_ZERO) && !wr_offset) |=> (off_cur == $past(last_filt)))
      else $error("offset coefficient not stored");

   a_gain_store: assert property (
      (step_done && (state == ACS_FULL) && !wr_gain) |=> (gain_cur == $past(last_filt)))
      else $error("gain coefficient not stored");

   a_no_start: assert property ((wr_mode && !wcode[2] && !busy) |=> !busy)
      else $error("non-calibration code started a calibration");
endmodule
`default_nettype wire

// *** tb/acs_filter_model.sv ***
// file: filter result source standing in for the decimation filter
// assumes one result every PER clocks on the shared sys_clk
`timescale 1ns/10ps
`default_nettype none
module acs_filter_model #(
   parameter int PER = 16
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [23:0] level,
   output logic [23:0] filt_data,
   output var logic filt_valid
);
   int cnt;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cnt <= 0;
         filt_valid <= 1'b0;
      end else begin
         cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
         filt_valid <= (cnt == PER - 1);
      end
   end
   // data line shows garbage outside the strobe
   assign filt_data = filt_valid ? level : ~level;
endmodule
`default_nettype wire

// *** tb/adc_calibration_sequencer_tb.sv ***
// file: self-checking bench for the calibration sequencer
// assumes sf=1 so one output period is 16 clocks
`timescale 1ns/10ps
`default_nettype none
module adc_calibration_sequencer_tb;
   import acs_pkg::*;
   logic sys_clk, rst, reg_wr, reg_rd, filt_valid, rdy_n, conv_valid;
   logic fe_short_inputs, fe_ref_fullscale, bipolar, filt_chop, filt_skip_eff;
   logic [2:0] reg_addr, conv_mode, pga_range;
   logic [31:0] reg_wdata, reg_rdata, rd_val;
   logic [23:0] filt_data, conv_data, level, cd;
   int n_mismatch, checks_done, n_conv;

   acs_sequencer uut(.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .filt_data, .filt_valid, .rdy_n, .conv_mode, .conv_data, .conv_valid, .fe_short_inputs,
      .fe_ref_fullscale, .pga_range, .bipolar, .filt_chop, .filt_skip_eff);
   acs_filter_model fm(.sys_clk, .rst, .level, .filt_data, .filt_valid);

   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   always @(posedge sys_clk) if (conv_valid === 1'b1) n_conv++;

   task automatic close_out();
      if (n_mismatch == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [2:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [2:0] a);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 rd_val = reg_rdata;
   endtask

   task automatic get_conv();
      int k;
      k = 0;
      @(posedge sys_clk);
      #1;
      while (conv_valid !== 1'b1 && k < 100) begin
         @(posedge sys_clk);
         #1;
         k++;
      end
      check("conv strobe", conv_valid, 1'b1);
      cd = conv_data;
   endtask

   // one calibration on channel 1, range 2, skip requested
   task automatic cal(input logic [2:0] code, input logic chop, input logic [23:0] lvl);
      int n, n_ref, per, exp_ref;
      logic [31:0] off0, gain0;
      logic full;
      full = (code == CODE_INT_FULL);
      per = (full ? 44 : 22) + (chop ? 0 : (full ? 4 : 2));
      exp_ref = full ? per * 8 : 0;
      level <= lvl;
      wr(ADDR_FILTER, {16'h0, 8'h01, 6'h0, 1'b1, chop});
      rd(ADDR_OFFSET);
      off0 = rd_val;
      rd(ADDR_GAIN);
      gain0 = rd_val;
      wr(ADDR_MODE, {23'h0, 2'h1, 1'b0, 3'h2, code});
      #1;
      n = 0;
      n_ref = 0;
      while (rdy_n !== 1'b1 && n < 16) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      check("ready high", rdy_n, 1'b1);
      check("short inputs", fe_short_inputs, code == CODE_INT_ZERO || full);
      check("range", pga_range, 3'h2);
      check("conv mode", conv_mode, 3'h0);
      check("skip gated", filt_skip_eff, 1'b0);
      check("chop", filt_chop, chop);
      while (rdy_n === 1'b1 && n < 1000) begin
         if (fe_ref_fullscale === 1'b1) n_ref++;
         @(posedge sys_clk);
         #1;
         n++;
      end
      // first period may be short: modulator runs free
      check("cal length", n + 15 >= per * 16 && n <= per * 16, 1'b1);
      check("full step", n_ref + 4 >= exp_ref && n_ref <= exp_ref + 4, 1'b1);
      check("ready low", rdy_n, 1'b0);
      rd(ADDR_MODE);
      check("mode idle", rd_val, {23'h0, 2'h1, 1'b0, 3'h2, 3'h0});
      rd(ADDR_OFFSET);
      check("offset", rd_val, code == CODE_SYS_FULL ? off0 : {8'h0, lvl});
      rd(ADDR_GAIN);
      check("gain", rd_val, code[0] ? {8'h0, lvl} : gain0);
   endtask

   initial begin
      rst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 3'h0;
      reg_wdata = 32'h0;
      level = 24'h0;
      n_mismatch = 0;
      checks_done = 0;
      n_conv = 0;
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      rd(ADDR_MODE);
      check("mode reset", rd_val, MODE_RST);
      rd(ADDR_FILTER);
      check("filter reset", rd_val, 32'h00000801);
      rd(ADDR_OFFSET);
      check("offset reset", rd_val, 32'h00800000);
      rd(ADDR_GAIN);
      check("gain reset", rd_val, 32'h00800000);
      wr(3'h7, 32'hffffffff);
      rd(3'h7);
      check("unmapped", rd_val, 32'h0);
      wr(ADDR_MODE, {23'h0, 2'h1, 1'b0, 3'h2, 3'h0});
      // host order: full-scale then zero-scale, system zero before full
      cal(CODE_INT_FULL, 1'b1, 24'h123456);
      cal(CODE_INT_ZERO, 1'b1, 24'h0a0b0c);
      cal(CODE_SYS_ZERO, 1'b1, 24'h212223);
      cal(CODE_SYS_FULL, 1'b1, 24'h7e5d4c);
      cal(CODE_INT_FULL, 1'b0, 24'h3c3c3c);
      cal(CODE_SYS_ZERO, 1'b0, 24'h404142);
      cal(CODE_INT_ZERO, 1'b0, 24'h0f1e2d);
      check("no restart", n_conv, 0);
      wr(ADDR_GAIN, 32'h00800000);
      wr(ADDR_MODE, {23'h0, 2'h1, 1'b1, 3'h2, 3'h1});
      #1;
      check("conv mode 1", conv_mode, 3'h1);
      check("bipolar", bipolar, 1'b1);
      get_conv();
      check("bipolar zero", cd, 24'h800000);
      level <= 24'h0f1e32;
      get_conv();
      get_conv();
      check("corrected", cd, 24'h800005);
      wr(ADDR_MODE, {23'h0, 2'h1, 1'b1, 3'h2, 3'h2});
      #1;
      check("conv mode 2", conv_mode, 3'h2);
      close_out();
   end

   initial begin
      #(20000 * 100);
      n_mismatch++;
      close_out();
   end
endmodule
`default_nettype wire
